// File: dv/tb_top.sv
// self-checking bench for the slip and receive pattern interrupt block
`timescale 1ns/10ps
`default_nettype none
`include "sprq_defines.svh"

module tb_top;
    localparam logic [11:0] a_st = {`SPRQ_IDX_SLIP_STATUS, 2'b00};
    localparam logic [11:0] a_ie = {`SPRQ_IDX_SLIP_IE, 2'b00};
    localparam logic [11:0] a_pst = {`SPRQ_IDX_PAT_STATUS, 2'b00};
    localparam logic [11:0] a_pie = {`SPRQ_IDX_PAT_IE, 2'b00};

    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic tx_overflow = 1'b0;
    logic tx_underflow = 1'b0;
    logic rx_overflow = 1'b0;
    logic rx_underflow = 1'b0;
    logic auxiliary_pattern_in = 1'b0;
    logic crc4_interwork_in = 1'b0;
    int mismatches = 0;
    int samples_checked = 0;
    // behavioural model of the registers
    int m_st = 0, m_ie = 0, m_pie = 0;
    int m_aux = 0, m_crc = 0, m_ach = 0, m_cch = 0;
    logic [31:0] rdata;
    logic rerr;
    logic [7:0] ev_bits [4] = '{8'ha0, 8'h60, 8'h05, 8'h03};
    int pos [6] = '{7, 6, 5, 2, 1, 0};
    int evmap [6] = '{0, 1, 0, 2, 3, 2};

    // 100 ns period
    always #50 clk_sys = ~clk_sys;

    sprq_top dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_overflow(tx_overflow),
        .tx_underflow(tx_underflow), .rx_overflow(rx_overflow),
        .rx_underflow(rx_underflow),
        .auxiliary_pattern_in(auxiliary_pattern_in),
        .crc4_interwork_in(crc4_interwork_in), .irq(irq)
    );

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic chk_word(string what, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic chk_bit(string what, logic exp, logic got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    function automatic logic exp_irq();
        return ((m_st & m_ie) != 0)
            || ((((m_ach << 6) | (m_cch << 4)) & m_pie) != 0);
    endfunction : exp_irq

    function automatic logic [31:0] pat_val();
        return 32'((m_aux << 7) | (m_ach << 6) | (m_crc << 5) | (m_cch << 4));
    endfunction : pat_val

    // one apb transfer; the wait for pready is bounded
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        // look just after each edge, once the slave's outputs have settled
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            chk_bit("pready wait", 1'b1, pready);
            end_sim();
        end
        // the answer stands now; the master samples it at the next edge
        rdata = prdata;
        rerr = pslverr;
        @(posedge clk_sys);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // write and update the model; write-one clears the sticky flags
    task automatic wr(logic [11:0] a, logic [31:0] d);
        apb(1'b1, a, d);
        chk_bit("pslverr", 1'b0, rerr);
        case (a)
            a_st: m_st = m_st & ~int'(d[7:0]);
            a_ie: m_ie = int'(d[7:0] & 8'he7);
            a_pst: begin
                m_ach = m_ach & ~int'(d[6]);
                m_cch = m_cch & ~int'(d[4]);
            end
            default: m_pie = int'(d[7:0] & 8'h50);
        endcase
        #1 chk_bit("irq", exp_irq(), irq);
    endtask : wr

    // read, compare, then clear what the read returned
    task automatic rd(logic [11:0] a, string what);
        logic [31:0] exp;
        exp = (a == a_st) ? 32'(m_st) : (a == a_ie) ? 32'(m_ie) :
              (a == a_pst) ? pat_val() : (a == a_pie) ? 32'(m_pie) : 32'h0;
        apb(1'b0, a, 32'h0);
        chk_word(what, exp, rdata);
        chk_bit("pslverr", !(a inside {a_st, a_ie, a_pst, a_pie}), rerr);
        if (a == a_st) m_st = 0;
        if (a == a_pst) begin
            m_ach = 0;
            m_cch = 0;
        end
        #1 chk_bit("irq", exp_irq(), irq);
    endtask : rd

    // one-cycle slip buffer event
    task automatic fire(int e);
        @(posedge clk_sys);
        {tx_overflow, tx_underflow, rx_overflow, rx_underflow} <= 4'(8 >> e);
        @(posedge clk_sys);
        {tx_overflow, tx_underflow, rx_overflow, rx_underflow} <= 4'h0;
        m_st = m_st | int'(ev_bits[e]);
        #1 chk_bit("irq", exp_irq(), irq);
    endtask : fire

    // detector levels take two edges through the synchroniser and a third into the change flag and irq
    task automatic set_det(int aux, int crc);
        @(posedge clk_sys);
        auxiliary_pattern_in <= 1'(aux);
        crc4_interwork_in <= 1'(crc);
        if (aux != m_aux) m_ach = 1;
        if (crc != m_crc) m_cch = 1;
        m_aux = aux;
        m_crc = crc;
        repeat (3) @(posedge clk_sys);
        #1 chk_bit("irq", exp_irq(), irq);
    endtask : set_det

    initial begin
        int i;
        int e;
        logic [7:0] v;
        void'($urandom(33365));
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(a_st, "slip status");
        rd(a_ie, "slip enable");
        rd(a_pst, "pattern status");
        rd(a_pie, "pattern enable");
        rd(12'h030, "unmapped");
        wr(a_ie, $urandom | 32'h18);
        rd(a_ie, "slip enable");
        $display("test reset and enables done");
        // one-hot enables first, then random enables and events
        for (i = 0; i < 12; i++) begin
            v = (i < 6) ? 8'(1 << pos[i]) : 8'($urandom);
            e = (i < 6) ? evmap[i] : int'($urandom_range(3));
            wr(a_ie, {24'h0, v});
            fire(e);
            rd(a_st, "slip status");
        end
        $display("test slip events done");
        wr(a_ie, 32'he7);
        fire(0);
        fire(3);
        wr(a_st, $urandom | 32'h80);
        rd(a_st, "slip status");
        $display("test write clear done");
        wr(a_pie, 32'hff);
        rd(a_pie, "pattern enable");
        set_det(1, 0);
        rd(a_pst, "pattern status");
        set_det(1, 1);
        set_det(0, 1);
        wr(a_pst, 32'h4f);
        rd(a_pst, "pattern status");
        wr(a_pie, 32'h0);
        set_det(0, 0);
        rd(a_pst, "pattern status");
        $display("test pattern status done");
        end_sim();
    end
endmodule : tb_top

`default_nettype wire

// File: rtl/sprq_defines.svh
// register map, field positions, masks and reset values of the slip irq block
//
// Functional notes
// - Enable bit 7 passes the transmit buffer-full event to the interrupt.
// - Enable bit 6 passes the transmit buffer-empty event to the interrupt.
// - Enable bit 5 passes the transmit slip event to the interrupt.
// - Enable bit 2 passes the receive buffer-full event to the interrupt.
// - Enable bit 1 passes the receive buffer-empty event to the interrupt.
// - Enable bit 0 passes the receive slip event to the interrupt.
// - Pattern status bit 7 reads the live auxiliary pattern detect state.
// - A change of the auxiliary pattern state sets bit 6 and interrupts.
// - Pattern status bit 5 reads the live CRC-4 interworking state.
// - A change of the interworking state sets bit 4 and interrupts.
// - A buffer overflow that discards a frame reports the full event.
// - A buffer underflow that repeats a frame reports the empty event.
// - A full or empty event in a direction also reports that slip event.
`ifndef SPRQ_DEFINES_SVH
`define SPRQ_DEFINES_SVH

// register indexes; byte address is four times the index
`define SPRQ_IDX_SLIP_STATUS 10'h008
`define SPRQ_IDX_SLIP_IE 10'h009
`define SPRQ_IDX_PAT_STATUS 10'h00a
`define SPRQ_IDX_PAT_IE 10'h00b

// slip status and slip enable bit positions
`define SPRQ_B_TX_FULL 7
`define SPRQ_B_TX_EMPTY 6
`define SPRQ_B_TX_SLIP 5
`define SPRQ_B_RX_FULL 2
`define SPRQ_B_RX_EMPTY 1
`define SPRQ_B_RX_SLIP 0

// receive pattern status bit positions
`define SPRQ_B_AUX_STATE 7
`define SPRQ_B_AUX_CHG 6
`define SPRQ_B_CRC_STATE 5
`define SPRQ_B_CRC_CHG 4

// writable and sticky masks
`define SPRQ_SLIP_MASK 8'he7
`define SPRQ_PAT_MASK 8'h50

// reset values
`define SPRQ_RST_SLIP_IE 8'h00
`define SPRQ_RST_SLIP_ST 8'h00
`define SPRQ_RST_PAT_IE 8'h00

`endif

// File: rtl/sprq_pkg.sv
// types of the slip and receive pattern interrupt block
package sprq_pkg;

    // apb answer sequencer, one-hot
    typedef enum logic [1:0] {
        SPRQ_ST_IDLE = 2'b01,
        SPRQ_ST_ANS = 2'b10
    } sprq_apb_st_t;

    // whole state of the main module
    typedef struct packed {
        sprq_apb_st_t fsm;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
        logic [7:0] slip_ie;
        logic [7:0] slip_st;
        logic [7:0] pat_ie;
        logic aux_state;
        logic aux_chg;
        logic crc_state;
        logic crc_chg;
    } sprq_state_t;

    // state of the two-stage synchroniser
    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] sync;
    } sprq_sync_t;

endpackage : sprq_pkg

// File: rtl/sprq_sync.sv
// two flip-flop synchroniser for the detector state levels
`timescale 1ns/10ps
`default_nettype none

module sprq_sync
    import sprq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [1:0] din,
    output logic [1:0] dout
);

    sprq_sync_t s;
    sprq_sync_t next_s;

    // meta feeds only the second stage
    always_comb begin
        next_s = s;
        next_s.meta = din;
        next_s.sync = s.meta;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign dout = s.sync;

endmodule : sprq_sync

`default_nettype wire

// File: rtl/sprq_top.sv
// slip buffer and receive pattern interrupt registers behind an apb slave
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "sprq_defines.svh"

module sprq_top
    import sprq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // one-cycle events from the slip buffers, same clock
    input wire logic tx_overflow,
    input wire logic tx_underflow,
    input wire logic rx_overflow,
    input wire logic rx_underflow,
    // detector levels from the receive line side, asynchronous
    input wire logic auxiliary_pattern_in,
    input wire logic crc4_interwork_in,
    // channel interrupt, active high level
    output logic irq
);

    sprq_state_t s;
    sprq_state_t next_s;
    logic [1:0] det_sync;
    logic aux_s;
    logic crc_s;
    logic [7:0] slip_evt;

    // true when the word address matches a register index and the two low address bits are zero
    function automatic logic reg_sel(input logic [11:0] addr,
                                     input logic [9:0] idx);
        reg_sel = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
    endfunction : reg_sel

    // true when any register is addressed
    function automatic logic reg_hit(input logic [11:0] addr);
        reg_hit = reg_sel(addr, `SPRQ_IDX_SLIP_STATUS)
            || reg_sel(addr, `SPRQ_IDX_SLIP_IE)
            || reg_sel(addr, `SPRQ_IDX_PAT_STATUS)
            || reg_sel(addr, `SPRQ_IDX_PAT_IE);
    endfunction : reg_hit

    // interrupt term for a given flag and enable set
    function automatic logic irq_term(input sprq_state_t st);
        logic [7:0] pat_flags;
        pat_flags = 8'h00;
        pat_flags[`SPRQ_B_AUX_CHG] = st.aux_chg;
        pat_flags[`SPRQ_B_CRC_CHG] = st.crc_chg;
        irq_term = (|(st.slip_st & st.slip_ie))
            || (|(pat_flags & st.pat_ie));
    endfunction : irq_term

    // detector levels cross in through two flops each
    sprq_sync u_det_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .din({crc4_interwork_in, auxiliary_pattern_in}),
        .dout(det_sync)
    );

    assign aux_s = det_sync[0];
    assign crc_s = det_sync[1];

    // slip follows either full or empty in the same direction
    always_comb begin
        slip_evt = 8'h00;
        slip_evt[`SPRQ_B_TX_FULL] = tx_overflow;
        slip_evt[`SPRQ_B_TX_EMPTY] = tx_underflow;
        slip_evt[`SPRQ_B_TX_SLIP] = tx_overflow | tx_underflow;
        slip_evt[`SPRQ_B_RX_FULL] = rx_overflow;
        slip_evt[`SPRQ_B_RX_EMPTY] = rx_underflow;
        slip_evt[`SPRQ_B_RX_SLIP] = rx_overflow | rx_underflow;
    end

    // next state: bus answer, register writes, flag set and clear
    always_comb begin
        logic done;
        logic hit;
        logic [7:0] rd_val;
        logic [7:0] wd;
        logic [7:0] slip_clr;
        logic pat_aux_clr;
        logic pat_crc_clr;
        next_s = s;
        done = 1'b0;
        hit = reg_hit(paddr);
        rd_val = 8'h00;
        wd = pwdata[7:0];
        slip_clr = 8'h00;
        pat_aux_clr = 1'b0;
        pat_crc_clr = 1'b0;

        // read value, snapped when the answer is prepared
        if (reg_sel(paddr, `SPRQ_IDX_SLIP_STATUS)) begin
            rd_val = s.slip_st;
        end else if (reg_sel(paddr, `SPRQ_IDX_SLIP_IE)) begin
            rd_val = s.slip_ie;
        end else if (reg_sel(paddr, `SPRQ_IDX_PAT_STATUS)) begin
            rd_val[`SPRQ_B_AUX_STATE] = s.aux_state;
            rd_val[`SPRQ_B_AUX_CHG] = s.aux_chg;
            rd_val[`SPRQ_B_CRC_STATE] = s.crc_state;
            rd_val[`SPRQ_B_CRC_CHG] = s.crc_chg;
        end else if (reg_sel(paddr, `SPRQ_IDX_PAT_IE)) begin
            rd_val = s.pat_ie;
        end

        // one wait state, then pready for one cycle
        case (s.fsm)
            SPRQ_ST_IDLE: begin
                if (psel && penable) begin
                    next_s.fsm = SPRQ_ST_ANS;
                    next_s.pready = 1'b1;
                    next_s.pslverr = !hit;
                    next_s.prdata = (pwrite || !hit) ? 32'h0000_0000
                                                     : {24'h00_0000, rd_val};
                end
            end
            SPRQ_ST_ANS: begin
                done = psel && penable;
                next_s.fsm = SPRQ_ST_IDLE;
                next_s.pready = 1'b0;
                next_s.pslverr = 1'b0;
                next_s.prdata = 32'h0000_0000;
            end
            default: begin
                next_s.fsm = SPRQ_ST_IDLE;
                next_s.pready = 1'b0;
                next_s.pslverr = 1'b0;
                next_s.prdata = 32'h0000_0000;
            end
        endcase

        // writes take effect at the edge that samples pready high
        if (done && pwrite) begin
            if (reg_sel(paddr, `SPRQ_IDX_SLIP_IE)) begin
                next_s.slip_ie = wd & `SPRQ_SLIP_MASK;
            end
            if (reg_sel(paddr, `SPRQ_IDX_PAT_IE)) begin
                next_s.pat_ie = wd & `SPRQ_PAT_MASK;
            end
            if (reg_sel(paddr, `SPRQ_IDX_SLIP_STATUS)) begin
                slip_clr = wd & `SPRQ_SLIP_MASK;
            end
            if (reg_sel(paddr, `SPRQ_IDX_PAT_STATUS)) begin
                pat_aux_clr = wd[`SPRQ_B_AUX_CHG];
                pat_crc_clr = wd[`SPRQ_B_CRC_CHG];
            end
        end

        // a read clears only the bits it returned, so a flag set
        // during the wait state is never lost unseen
        if (done && !pwrite) begin
            if (reg_sel(paddr, `SPRQ_IDX_SLIP_STATUS)) begin
                slip_clr = s.prdata[7:0] & `SPRQ_SLIP_MASK;
            end
            if (reg_sel(paddr, `SPRQ_IDX_PAT_STATUS)) begin
                pat_aux_clr = s.prdata[`SPRQ_B_AUX_CHG];
                pat_crc_clr = s.prdata[`SPRQ_B_CRC_CHG];
            end
        end

        // sticky flags: a new event wins over a clear in the same cycle
        next_s.slip_st = (s.slip_st & ~slip_clr) | slip_evt;
        next_s.aux_state = aux_s;
        next_s.crc_state = crc_s;
        next_s.aux_chg = (s.aux_chg && !pat_aux_clr)
            || (aux_s != s.aux_state);
        next_s.crc_chg = (s.crc_chg && !pat_crc_clr)
            || (crc_s != s.crc_state);

        // level interrupt from the flags and enables of the next cycle
        next_s.irq = irq_term(next_s);
    end

    // all state in one register; constant reset values only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{fsm: SPRQ_ST_IDLE, slip_ie: `SPRQ_RST_SLIP_IE,
                   slip_st: `SPRQ_RST_SLIP_ST, pat_ie: `SPRQ_RST_PAT_IE,
                   default: '0};
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign irq = s.irq;

    // checks on the design's own outputs and state
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_irq_flag_gate: assert property (
        irq == irq_term(s)
    ) else $error("irq does not match enabled flags");

    a_tx_full_flag: assert property (
        tx_overflow |=> s.slip_st[`SPRQ_B_TX_FULL]
            && s.slip_st[`SPRQ_B_TX_SLIP]
    ) else $error("tx overflow did not set full and slip");

    a_rx_empty_flag: assert property (
        rx_underflow |=> s.slip_st[`SPRQ_B_RX_EMPTY]
            && s.slip_st[`SPRQ_B_RX_SLIP]
    ) else $error("rx underflow did not set empty and slip");

    a_slip_needs_cause: assert property (
        !s.slip_st[`SPRQ_B_RX_SLIP] && !rx_overflow && !rx_underflow
            |=> !s.slip_st[`SPRQ_B_RX_SLIP]
    ) else $error("rx slip flag set without a cause");

    a_tx_full_irq: assert property (
        s.slip_st[`SPRQ_B_TX_FULL] && s.slip_ie[`SPRQ_B_TX_FULL]
            |-> irq
    ) else $error("enabled tx full flag without irq");

    a_masked_no_irq: assert property (
        (s.slip_st & s.slip_ie) == 8'h00 && !(s.aux_chg && s.pat_ie[6])
            && !(s.crc_chg && s.pat_ie[4]) |-> !irq
    ) else $error("irq with every flag masked");

    a_enable_reserved: assert property (
        s.slip_ie[4:3] == 2'b00
    ) else $error("reserved enable bits not zero");

    a_aux_live_state: assert property (
        s.aux_state == $past(aux_s)
    ) else $error("aux state does not follow detector");

    a_aux_change_flag: assert property (
        aux_s != s.aux_state
            |=> s.aux_chg && (s.aux_state != $past(s.aux_state))
    ) else $error("aux change did not set its flag");

    a_crc_change_flag: assert property (
        (crc_s != s.crc_state) && s.pat_ie[4]
            |=> s.crc_chg && (irq || !s.pat_ie[4])
    ) else $error("crc change did not raise flag and irq");

    a_crc_live_state: assert property (
        s.crc_state == $past(crc_s)
    ) else $error("crc state does not follow detector");

    a_flag_sticky: assert property (
        s.slip_st[`SPRQ_B_TX_FULL] && s.fsm == SPRQ_ST_IDLE
            |=> s.slip_st[`SPRQ_B_TX_FULL]
    ) else $error("tx full flag dropped without an access");

    a_pready_pulse: assert property (
        psel && penable && s.fsm == SPRQ_ST_IDLE |=> pready ##1 !pready
    ) else $error("pready not a single cycle after one wait");

    // per-bit gating and flag setting of the remaining events, clearing of tx full by write and aux change by read
    a_tx_empty_irq: assert property (
        s.slip_st[`SPRQ_B_TX_EMPTY] && s.slip_ie[`SPRQ_B_TX_EMPTY] |-> irq
    ) else $error("enabled tx empty flag without irq");

    a_tx_slip_irq: assert property (
        s.slip_st[`SPRQ_B_TX_SLIP] && s.slip_ie[`SPRQ_B_TX_SLIP] |-> irq
    ) else $error("enabled tx slip flag without irq");

    a_rx_full_irq: assert property (
        s.slip_st[`SPRQ_B_RX_FULL] && s.slip_ie[`SPRQ_B_RX_FULL] |-> irq
    ) else $error("enabled rx full flag without irq");

    a_rx_empty_irq: assert property (
        s.slip_st[`SPRQ_B_RX_EMPTY] && s.slip_ie[`SPRQ_B_RX_EMPTY] |-> irq
    ) else $error("enabled rx empty flag without irq");

    a_rx_slip_irq: assert property (
        s.slip_st[`SPRQ_B_RX_SLIP] && s.slip_ie[`SPRQ_B_RX_SLIP] |-> irq
    ) else $error("enabled rx slip flag without irq");

    a_tx_empty_flag: assert property (
        tx_underflow |=> s.slip_st[`SPRQ_B_TX_EMPTY]
            && s.slip_st[`SPRQ_B_TX_SLIP]
    ) else $error("tx underflow did not set empty and slip");

    a_rx_full_flag: assert property (
        rx_overflow |=> s.slip_st[`SPRQ_B_RX_FULL]
            && s.slip_st[`SPRQ_B_RX_SLIP]
    ) else $error("rx overflow did not set full and slip");

    a_tx_slip_cause: assert property (
        !s.slip_st[`SPRQ_B_TX_SLIP] && !tx_overflow && !tx_underflow
            |=> !s.slip_st[`SPRQ_B_TX_SLIP]
    ) else $error("tx slip flag set without a cause");

    a_pat_reserved: assert property (
        (s.pat_ie & ~`SPRQ_PAT_MASK) == 8'h00
    ) else $error("reserved pattern enable bits not zero");

    a_aux_flag_sticky: assert property (
        s.aux_chg && s.fsm == SPRQ_ST_IDLE |=> s.aux_chg
    ) else $error("aux change flag dropped without an access");

    a_crc_flag_sticky: assert property (
        s.crc_chg && s.fsm == SPRQ_ST_IDLE |=> s.crc_chg
    ) else $error("crc change flag dropped without an access");

    a_unmapped_err: assert property (
        psel && penable && s.fsm == SPRQ_ST_IDLE && !reg_hit(paddr)
            |=> pslverr && prdata == 32'h0000_0000
    ) else $error("unmapped access without error answer");

    a_idle_bus_quiet: assert property (
        !pready |-> !pslverr && prdata == 32'h0000_0000
    ) else $error("error or read data outside an answer");

    a_slip_write_clr: assert property (
        s.fsm == SPRQ_ST_ANS && psel && penable && pwrite
            && reg_sel(paddr, `SPRQ_IDX_SLIP_STATUS)
            && pwdata[`SPRQ_B_TX_FULL] && !tx_overflow
            |=> !s.slip_st[`SPRQ_B_TX_FULL]
    ) else $error("write of one did not clear tx full flag");

    a_aux_read_clr: assert property (
        s.fsm == SPRQ_ST_ANS && psel && penable && !pwrite
            && reg_sel(paddr, `SPRQ_IDX_PAT_STATUS)
            && s.prdata[`SPRQ_B_AUX_CHG] && aux_s == s.aux_state
            |=> !s.aux_chg
    ) else $error("read did not clear returned aux change flag");

    a_slip_ie_write: assert property (
        s.fsm == SPRQ_ST_ANS && psel && penable && pwrite
            && reg_sel(paddr, `SPRQ_IDX_SLIP_IE)
            |=> s.slip_ie == ($past(pwdata[7:0]) & `SPRQ_SLIP_MASK)
    ) else $error("slip enable write not taken as masked");

endmodule : sprq_top

`default_nettype wire
